// file: rtl/wtmr_pkg.sv
// Package for the wide timer: register map, fields and reset values
package wtmr_pkg;
    localparam logic [7:0] WTMR_CTRL_OFF = 8'h10;
    localparam logic [7:0] WTMR_CNT_LO_OFF = 8'h14;
    localparam logic [7:0] WTMR_CNT_HI_OFF = 8'h18;
    localparam logic [7:0] WTMR_FLAGS_OFF = 8'h1C;
    localparam logic [7:0] WTMR_ENABLES_OFF = 8'h20;
    localparam logic [7:0] WTMR_PORTDIR_OFF = 8'h24;
    localparam int WTMR_RUN_BIT = 0;
    localparam int WTMR_SRC_BIT = 1;
    localparam int WTMR_SYNC_BIT = 2;
    localparam int WTMR_OSC_BIT = 3;
    localparam int WTMR_PS_LO_BIT = 4;
    localparam int WTMR_PS_HI_BIT = 5;
    localparam int WTMR_WRAP_BIT = 0;
    localparam logic [5:0] WTMR_CTRL_RST = 6'h00;
    localparam logic [7:0] WTMR_PORTDIR_RST = 8'hFF;
    localparam logic [15:0] WTMR_CNT_MAX = 16'hFFFF;
    localparam logic [15:0] WTMR_CNT_RST = 16'h0000;
    localparam logic [2:0] WTMR_PS_RST = 3'h0;
    localparam logic [31:0] WTMR_RD_ZERO = 32'h0000_0000;
endpackage

// file: rtl/wtmr_top.sv
// Sixteen-bit wide timer/counter with APB register access
`timescale 1ns/100ps
// Overview of operation
// - Source select bit chooses instruction clock (clear) or external pin (set)
// - Timer mode advances count once per instruction cycle after prescale
// - Counter mode advances only on rising edges of external clock
// - Oscillator enable forces both oscillator pins to inputs, ignoring direction bits
// - Capture/compare unit can clear the count through an internal reset input
// - Oscillator enable bit starts the crystal oscillator; clearing stops it
// - Low-frequency oscillator keeps running during sleep
// - Count runs upward 0000h to FFFFh then wraps to 0000h
// - Each wrap sets the latched wrap flag
// - Interrupt request only while wrap interrupt enable is set
// - Count runs only while run enable is set, else holds
// - Special event trigger clears count without setting wrap flag
// - Software count write wins over a coinciding special event trigger
module wtmr_top
    import wtmr_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic ext_count_clock_pin,
    input wire logic osc_in_pin,
    input wire logic sleep_mode,
    input wire logic special_event_trigger,
    output logic osc_out_pin,
    output logic osc_run,
    output logic [1:0] pin_output_enable,
    output logic wrap_irq
);
    typedef struct packed {
        logic [5:0] ctrl;
        logic [15:0] count;
        logic [2:0] pscnt;
        logic wrap_flag;
        logic wrap_irq_enable;
        logic [7:0] port_c_direction;
        logic ext_s1;
        logic ext_s2;
        logic ext_prev;
        logic ext_raw_prev;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic osc_out;
        logic osc_run;
        logic [1:0] pin_oe;
        logic irq;
        logic ps8_armed;
        logic [3:0] ps8_gap;
    } wtmr_state_type;

    wtmr_state_type s_q;
    wtmr_state_type s_d;

    logic wr_acc;
    logic rd_acc;
    logic ext_rise;
    logic tick;
    logic ps_hit;
    logic [2:0] ps_mask;
    logic [15:0] cnt_next;
    logic map_hit;
    logic wrap_set;
    logic ps8_run;
    logic ps8_step;

    always_comb begin
        s_d = s_q;
        wr_acc = psel && penable && pwrite && !s_q.pready;
        rd_acc = psel && penable && !pwrite && !s_q.pready;
        map_hit = (paddr == WTMR_CTRL_OFF) || (paddr == WTMR_CNT_LO_OFF)
            || (paddr == WTMR_CNT_HI_OFF) || (paddr == WTMR_FLAGS_OFF)
            || (paddr == WTMR_ENABLES_OFF) || (paddr == WTMR_PORTDIR_OFF);
        // Synchroniser: only the second stage is looked at
        s_d.ext_s1 = ext_count_clock_pin;
        s_d.ext_s2 = s_q.ext_s1;
        s_d.ext_prev = s_q.ext_s2;
        s_d.ext_raw_prev = ext_count_clock_pin;
        // Unsynchronised path samples the pin directly; one clock only here
        if (s_q.ctrl[WTMR_SYNC_BIT]) begin
            ext_rise = ext_count_clock_pin && !s_q.ext_raw_prev;
        end else begin
            ext_rise = s_q.ext_s2 && !s_q.ext_prev;
        end
        if (s_q.ctrl[WTMR_SRC_BIT]) begin
            tick = ext_rise;
        end else begin
            tick = 1'b1;
        end
        ps_mask = 3'(({1'b0, s_q.ctrl[WTMR_PS_HI_BIT:WTMR_PS_LO_BIT]} == 3'h0) ? 3'h0 :
            (s_q.ctrl[WTMR_PS_HI_BIT:WTMR_PS_LO_BIT] == 2'b01) ? 3'h1 :
            (s_q.ctrl[WTMR_PS_HI_BIT:WTMR_PS_LO_BIT] == 2'b10) ? 3'h3 : 3'h7);
        ps_hit = ((s_q.pscnt & ps_mask) == ps_mask);
        cnt_next = s_q.count;
        wrap_set = 1'b0;
        if (s_q.ctrl[WTMR_RUN_BIT] && tick) begin
            s_d.pscnt = 3'(s_q.pscnt + 3'h1);
            if (ps_hit) begin
                s_d.pscnt = WTMR_PS_RST;
                cnt_next = 16'(s_q.count + 16'h0001);
                // A trigger in the same cycle is a reset, not a wrap
                if (s_q.count == WTMR_CNT_MAX && !special_event_trigger) begin
                    wrap_set = 1'b1;
                    s_d.wrap_flag = 1'b1;
                end
            end
        end
        if (special_event_trigger) begin
            cnt_next = WTMR_CNT_RST;
            s_d.pscnt = WTMR_PS_RST;
        end
        s_d.count = cnt_next;
        s_d.pready = psel && penable && !s_q.pready;
        s_d.pslverr = psel && penable && !s_q.pready && !map_hit;
        s_d.prdata = WTMR_RD_ZERO;
        if (wr_acc) begin
            unique case (paddr)
                WTMR_CTRL_OFF: begin
                    s_d.ctrl = pwdata[5:0];
                end
                WTMR_CNT_LO_OFF: begin
                    s_d.count[7:0] = pwdata[7:0];
                end
                WTMR_CNT_HI_OFF: begin
                    s_d.count[15:8] = pwdata[7:0];
                end
                WTMR_FLAGS_OFF: begin
                    // Set wins even when the flag already stood at one
                    s_d.wrap_flag = pwdata[WTMR_WRAP_BIT] || wrap_set;
                end
                WTMR_ENABLES_OFF: begin
                    s_d.wrap_irq_enable = pwdata[WTMR_WRAP_BIT];
                end
                WTMR_PORTDIR_OFF: begin
                    s_d.port_c_direction = pwdata[7:0];
                end
                default: begin
                end
            endcase
        end
        if (rd_acc) begin
            unique case (paddr)
                WTMR_CTRL_OFF: s_d.prdata = {26'h0, s_q.ctrl};
                WTMR_CNT_LO_OFF: s_d.prdata = {24'h0, s_q.count[7:0]};
                WTMR_CNT_HI_OFF: s_d.prdata = {24'h0, s_q.count[15:8]};
                WTMR_FLAGS_OFF: s_d.prdata = {31'h0, s_q.wrap_flag};
                WTMR_ENABLES_OFF: s_d.prdata = {31'h0, s_q.wrap_irq_enable};
                WTMR_PORTDIR_OFF: s_d.prdata = {24'h0, s_q.port_c_direction};
                default: s_d.prdata = WTMR_RD_ZERO;
            endcase
        end
        // Oscillator ignores sleep so the count can go on
        s_d.osc_run = s_d.ctrl[WTMR_OSC_BIT];
        s_d.osc_out = s_d.ctrl[WTMR_OSC_BIT] && !osc_in_pin;
        if (s_d.ctrl[WTMR_OSC_BIT]) begin
            s_d.pin_oe = 2'b00;
        end else begin
            s_d.pin_oe = ~s_d.port_c_direction[1:0];
        end
        s_d.irq = s_d.wrap_flag && s_d.wrap_irq_enable;
        // Spacing of count steps at 1:8, kept only for the prescale check
        ps8_run = s_q.ctrl[WTMR_RUN_BIT] && !s_q.ctrl[WTMR_SRC_BIT]
            && (s_q.ctrl[WTMR_PS_HI_BIT:WTMR_PS_LO_BIT] == 2'b11)
            && !special_event_trigger && !wr_acc;
        ps8_step = (s_d.count != s_q.count);
        if (!ps8_run) begin
            s_d.ps8_armed = 1'b0;
            s_d.ps8_gap = 4'h0;
        end else if (ps8_step) begin
            s_d.ps8_armed = 1'b1;
            s_d.ps8_gap = 4'h0;
        end else begin
            s_d.ps8_gap = 4'(s_q.ps8_gap + 4'h1);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '0;
            s_q.ctrl <= WTMR_CTRL_RST;
            s_q.port_c_direction <= WTMR_PORTDIR_RST;
        end else begin
            s_q <= s_d;
        end
    end

    assign prdata = s_q.prdata;
    assign pready = s_q.pready;
    assign pslverr = s_q.pslverr;
    assign osc_out_pin = s_q.osc_out;
    assign osc_run = s_q.osc_run;
    assign pin_output_enable = s_q.pin_oe;
    assign wrap_irq = s_q.irq;

    logic sleep_seen;
    assign sleep_seen = sleep_mode;

    wrap_sets_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
        (s_q.count == WTMR_CNT_MAX && s_d.count == WTMR_CNT_RST && !special_event_trigger)
        |=> s_q.wrap_flag)
        else $error("wrap did not set flag");
    run_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        (!s_q.ctrl[WTMR_RUN_BIT] && !special_event_trigger && !wr_acc)
        |=> s_q.count == $past(s_q.count))
        else $error("count moved while stopped");
    timer_step_a: assert property (@(posedge pclk) disable iff (!presetn)
        (s_q.ctrl[WTMR_RUN_BIT] && !s_q.ctrl[WTMR_SRC_BIT] && ps_mask == 3'h0
        && !special_event_trigger && !wr_acc && !$past(wr_acc))
        |=> s_q.count == 16'($past(s_q.count) + 16'h0001))
        else $error("timer did not advance");
    trig_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
        (special_event_trigger && !wr_acc) |=> s_q.count == WTMR_CNT_RST)
        else $error("trigger did not clear count");
    trig_noflag_a: assert property (@(posedge pclk) disable iff (!presetn)
        (special_event_trigger && !s_q.wrap_flag && !wr_acc) |=> !s_q.wrap_flag)
        else $error("trigger set wrap flag");
    write_wins_a: assert property (@(posedge pclk) disable iff (!presetn)
        (special_event_trigger && wr_acc && paddr == WTMR_CNT_LO_OFF)
        |=> s_q.count[7:0] == $past(pwdata[7:0]))
        else $error("write lost to trigger");
    irq_mask_a: assert property (@(posedge pclk) disable iff (!presetn)
        wrap_irq == (s_q.wrap_flag && s_q.wrap_irq_enable))
        else $error("irq does not follow flag and enable");
    osc_pins_a: assert property (@(posedge pclk) disable iff (!presetn)
        s_q.ctrl[WTMR_OSC_BIT] |-> pin_output_enable == 2'b00)
        else $error("osc pins driven");
    counter_rise_a: assert property (@(posedge pclk) disable iff (!presetn)
        (s_q.ctrl[WTMR_SRC_BIT] && !ext_rise && !special_event_trigger && !wr_acc)
        |=> s_q.count == $past(s_q.count))
        else $error("count without rising edge");
    wrap_c: cover property (@(posedge pclk) disable iff (!presetn) wrap_irq);
    trig_c: cover property (@(posedge pclk) disable iff (!presetn)
        special_event_trigger && wr_acc);
    ext_c: cover property (@(posedge pclk) disable iff (!presetn)
        s_q.ctrl[WTMR_SRC_BIT] && ext_rise && sleep_seen);
    ps8_c: cover property (@(posedge pclk) disable iff (!presetn)
        ps8_run && s_q.ps8_armed && ps8_step);
    osc_c: cover property (@(posedge pclk) disable iff (!presetn)
        osc_run && osc_out_pin);
    flag_set_wins_a: assert property (@(posedge pclk) disable iff (!presetn)
        (wrap_set && wr_acc && paddr == WTMR_FLAGS_OFF) |=> s_q.wrap_flag)
        else $error("clear beat wrap");
    flag_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
        (!wrap_set && wr_acc && paddr == WTMR_FLAGS_OFF && !pwdata[WTMR_WRAP_BIT])
        |=> !s_q.wrap_flag)
        else $error("flag not cleared");
    wrap_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
        (wrap_set && !wr_acc) |=> s_q.count == WTMR_CNT_RST)
        else $error("wrap did not reach zero");
    ps8_step_a: assert property (@(posedge pclk) disable iff (!presetn)
        (ps8_run && s_q.ps8_armed && ps8_step) |-> s_q.ps8_gap == 4'h7)
        else $error("early step at 1:8");
    ps8_late_a: assert property (@(posedge pclk) disable iff (!presetn)
        (ps8_run && s_q.ps8_armed) |-> s_q.ps8_gap < 4'h8)
        else $error("late step at 1:8");
    ps_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        (!s_q.ctrl[WTMR_RUN_BIT] && !special_event_trigger)
        |=> s_q.pscnt == $past(s_q.pscnt))
        else $error("prescaler moved while stopped");
    trig_ps_a: assert property (@(posedge pclk) disable iff (!presetn)
        special_event_trigger |=> s_q.pscnt == WTMR_PS_RST)
        else $error("trigger left prescaler");
    // Count source timing and oscillator off state
    sync_lag_a: assert property (@(posedge pclk) disable iff (!presetn)
        (s_q.ctrl[WTMR_SRC_BIT] && !s_q.ctrl[WTMR_SYNC_BIT] && ext_rise)
        |-> $past(ext_count_clock_pin, 2) && !$past(ext_count_clock_pin, 3))
        else $error("synchronised edge out of step");
    bypass_lag_a: assert property (@(posedge pclk) disable iff (!presetn)
        (s_q.ctrl[WTMR_SRC_BIT] && s_q.ctrl[WTMR_SYNC_BIT] && ext_rise)
        |-> ext_count_clock_pin && !$past(ext_count_clock_pin))
        else $error("direct edge out of step");
    osc_off_a: assert property (@(posedge pclk) disable iff (!presetn)
        !s_q.ctrl[WTMR_OSC_BIT] |-> !osc_out_pin && !osc_run)
        else $error("oscillator runs while off");
    // Bus answer shape
    pready_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
        pready |=> !pready)
        else $error("ready held");
    slverr_ready_a: assert property (@(posedge pclk) disable iff (!presetn)
        pslverr |-> pready)
        else $error("error without ready");
    rd_idle_a: assert property (@(posedge pclk) disable iff (!presetn)
        !pready |-> prdata == WTMR_RD_ZERO)
        else $error("read data outside answer");
    // Register readback
    read_lo_a: assert property (@(posedge pclk) disable iff (!presetn)
        (rd_acc && paddr == WTMR_CNT_LO_OFF)
        |=> prdata == {24'h00_0000, $past(s_q.count[7:0])})
        else $error("low byte read wrong");
    read_hi_a: assert property (@(posedge pclk) disable iff (!presetn)
        (rd_acc && paddr == WTMR_CNT_HI_OFF)
        |=> prdata == {24'h00_0000, $past(s_q.count[15:8])})
        else $error("high byte read wrong");
endmodule

// file: test/wtmr_ext_src.sv
// External count clock and crystal source model for the wide timer
`timescale 1ns/100ps
module wtmr_ext_src #(
    parameter int HALF = 3
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic go,
    output logic ext_clk
);
    logic [3:0] ph_q;
    // Stands still low outside bursts, so only commanded edges reach the pin
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ph_q <= 4'h0;
            ext_clk <= 1'b0;
        end else if (!go) begin
            ph_q <= 4'h0;
            ext_clk <= 1'b0;
        end else if (ph_q == 4'(HALF - 1)) begin
            ph_q <= 4'h0;
            ext_clk <= ~ext_clk;
        end else begin
            ph_q <= ph_q + 4'h1;
        end
    end
endmodule

// file: test/wtmr_top_test.sv
// Self-checking bench for the wide timer
`timescale 1ns/100ps
module wtmr_top_test;
    import wtmr_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, sleep_mode, trig, go, err;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rdata;
    logic pready, pslverr, ext_clk, osc_out_pin, osc_run, wrap_irq;
    logic [1:0] pin_oe;
    int bad_count = 0;
    int num_checks = 0;
    wtmr_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .ext_count_clock_pin(ext_clk), .osc_in_pin(ext_clk),
        .sleep_mode(sleep_mode), .special_event_trigger(trig), .osc_out_pin(osc_out_pin),
        .osc_run(osc_run), .pin_output_enable(pin_oe), .wrap_irq(wrap_irq));
    wtmr_ext_src u_src (.pclk(pclk), .presetn(presetn), .go(go), .ext_clk(ext_clk));
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask
    // Idle edge at the end keeps back-to-back calls from double driving psel
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // No answer time assumed; only the watchdog ends a hang
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rdata = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input string what);
        bus(1'b0, a, 32'h0000_0000);
        check(what, rdata, exp);
    endtask
    task automatic pulse_trig();
        trig <= 1'b1;
        @(posedge pclk);
        trig <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic give_verdict();
        $display("checks %0d, mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end
    initial begin
        #100us;
        bad_count++;
        give_verdict();
    end
    initial begin
        {presetn, psel, penable, pwrite, sleep_mode, trig, go} = 7'h00;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        rchk(WTMR_CTRL_OFF, 32'h0000_0000, "control reset");
        rchk(WTMR_PORTDIR_OFF, 32'h0000_00FF, "direction reset");
        rchk(8'h3C, 32'h0000_0000, "unmapped read");
        check("unmapped error", {31'h0, err}, 32'h0000_0001);
        wr(WTMR_CNT_LO_OFF, 32'h0000_00A5);
        wr(WTMR_CNT_HI_OFF, 32'h0000_003C);
        rchk(WTMR_CNT_LO_OFF, 32'h0000_00A5, "low byte");
        rchk(WTMR_CNT_HI_OFF, 32'h0000_003C, "high byte");
        $display("test registers done");
        // 39 idle cycles plus bus overhead give 43 timer ticks
        wr(WTMR_CNT_LO_OFF, 32'h0000_00F0);
        wr(WTMR_CNT_HI_OFF, 32'h0000_00FF);
        wr(WTMR_ENABLES_OFF, 32'h0000_0001);
        wr(WTMR_CTRL_OFF, 32'h0000_0001);
        repeat (39) @(posedge pclk);
        wr(WTMR_CTRL_OFF, 32'h0000_0000);
        rchk(WTMR_CNT_LO_OFF, 32'h0000_001B, "wrapped low");
        rchk(WTMR_CNT_HI_OFF, 32'h0000_0000, "wrapped high");
        rchk(WTMR_FLAGS_OFF, 32'h0000_0001, "wrap flag");
        check("irq enabled", {31'h0, wrap_irq}, 32'h0000_0001);
        repeat (10) @(posedge pclk);
        rchk(WTMR_CNT_LO_OFF, 32'h0000_001B, "held count");
        wr(WTMR_ENABLES_OFF, 32'h0000_0000);
        check("irq masked", {31'h0, wrap_irq}, 32'h0000_0000);
        // Wrap lands on the access edge of a flag clear; the set must win
        wr(WTMR_CNT_LO_OFF, 32'h0000_00FC);
        wr(WTMR_CNT_HI_OFF, 32'h0000_00FF);
        wr(WTMR_CTRL_OFF, 32'h0000_0001);
        wr(WTMR_FLAGS_OFF, 32'h0000_0000);
        wr(WTMR_CTRL_OFF, 32'h0000_0000);
        rchk(WTMR_FLAGS_OFF, 32'h0000_0001, "set beats clear");
        rchk(WTMR_CNT_LO_OFF, 32'h0000_0004, "count after race");
        wr(WTMR_FLAGS_OFF, 32'h0000_0000);
        $display("test wrap done");
        wr(WTMR_CNT_HI_OFF, 32'h0000_0077);
        pulse_trig();
        rchk(WTMR_CNT_HI_OFF, 32'h0000_0000, "trigger clear");
        rchk(WTMR_FLAGS_OFF, 32'h0000_0000, "no flag on trigger");
        wr(WTMR_CNT_HI_OFF, 32'h0000_0077);
        fork
            wr(WTMR_CNT_LO_OFF, 32'h0000_005A);
            begin
                @(posedge pclk);
                trig <= 1'b1;
                @(posedge pclk);
                trig <= 1'b0;
            end
        join
        rchk(WTMR_CNT_LO_OFF, 32'h0000_005A, "write beats trigger");
        rchk(WTMR_CNT_HI_OFF, 32'h0000_0000, "other byte cleared");
        $display("test trigger done");
        // 60 idle cycles plus bus overhead give 64 ticks, a multiple of every ratio
        for (int ps = 0; ps < 4; ps++) begin
            pulse_trig();
            wr(WTMR_CTRL_OFF, 32'(1 | (ps << 4)));
            repeat (60) @(posedge pclk);
            wr(WTMR_CTRL_OFF, 32'h0000_0000);
            rchk(WTMR_CNT_LO_OFF, 32'(64 >> ps), "prescaled count");
        end
        $display("test prescale done");
        sleep_mode <= 1'b1;
        for (int s = 0; s < 2; s++) begin
            pulse_trig();
            wr(WTMR_CTRL_OFF, 32'(3 | (s << 2)));
            go <= 1'b1;
            repeat (48) @(posedge pclk);
            go <= 1'b0;
            repeat (8) @(posedge pclk);
            wr(WTMR_CTRL_OFF, 32'h0000_0000);
            rchk(WTMR_CNT_LO_OFF, 32'h0000_0008, "pin edges");
        end
        sleep_mode <= 1'b0;
        $display("test counter done");
        wr(WTMR_PORTDIR_OFF, 32'h0000_0000);
        check("pins driven", {30'h0, pin_oe}, 32'h0000_0003);
        wr(WTMR_CTRL_OFF, 32'h0000_0008);
        check("pins forced in", {30'h0, pin_oe}, 32'h0000_0000);
        check("osc on", {31'h0, osc_run}, 32'h0000_0001);
        // Start-up allowance before the oscillator output is relied on
        repeat (16) @(posedge pclk);
        check("osc out", {31'h0, osc_out_pin}, 32'h0000_0001);
        wr(WTMR_CTRL_OFF, 32'h0000_0000);
        check("osc off", {31'h0, osc_run}, 32'h0000_0000);
        check("osc out off", {31'h0, osc_out_pin}, 32'h0000_0000);
        $display("test oscillator done");
        give_verdict();
    end
endmodule
